// ===== hdl/smp_port.sv
// serial programming port: core command decoder, page buffers and write timing
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_port #(
	parameter int PAGE_WAIT_CYC = `SMP_PAGE_WAIT_NS / `SMP_CLK_PERIOD_NS,
	parameter int BYTE_WAIT_CYC = `SMP_BYTE_WAIT_NS / `SMP_CLK_PERIOD_NS,
	parameter int ERASE_WAIT_CYC = `SMP_ERASE_WAIT_NS / `SMP_CLK_PERIOD_NS,
	parameter int PAGE_WORDS = 128,
	// arbitrary identity values
	parameter logic [23:0] SIGNATURE = 24'h5A_A5C3,
	parameter logic [7:0] CALIBRATION = 8'h80
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_reset_pin_b,
	input wire logic i_sck,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	output logic o_prog_mode,
	output logic o_cpu_run,
	output logic o_busy,
	output logic [23:0] o_pmem_raddr,
	input wire logic [15:0] i_pmem_rdata,
	output logic [9:0] o_nvm_raddr,
	input wire logic [7:0] i_nvm_rdata,
	output logic o_pmem_we,
	output logic [23:0] o_pmem_waddr,
	output logic [15:0] o_pmem_wdata,
	output logic o_nvm_we,
	output logic [9:0] o_nvm_waddr,
	output logic [7:0] o_nvm_wdata,
	output logic o_chip_erase,
	output logic [7:0] o_lock,
	output logic [7:0] o_fuse_lo,
	output logic [7:0] o_fuse_hi,
	output logic [7:0] o_fuse_ext
);
	localparam int CW = 19;

	if (ERASE_WAIT_CYC >= 2**CW || PAGE_WAIT_CYC >= 2**CW || BYTE_WAIT_CYC >= 2**CW ||
		PAGE_WAIT_CYC < 1 || BYTE_WAIT_CYC < 1 || ERASE_WAIT_CYC < 9 || PAGE_WORDS != 128)
	begin : g_bad_param
		$error("smp_port wait counts must fit 19 bits, erase at least 9, page of 128 words");
	end

	smp_link_if lif ();

	logic link_rst_b;
	logic tgl_s, tgl_prev_q;
	logic pin_s;
	logic new_instr, accept, prog_pin;
	logic [7:0] b1, b2, b3, b4;
	logic [15:0] pbuf [PAGE_WORDS];
	logic [7:0] nbuf [4];
	logic ld_lo, ld_hi, ld_nvm;

	smp_pkg::smp_state_t state_q, state_d;
	smp_pkg::smp_target_t tgt_q, tgt_d;
	logic enabled_q, enabled_d;
	logic [7:0] ext_q, ext_d;
	logic [7:0] lock_q, lock_d;
	logic [7:0] fuse_lo_q, fuse_lo_d;
	logic [7:0] fuse_hi_q, fuse_hi_d;
	logic [7:0] fuse_ext_q, fuse_ext_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [6:0] idx_q, idx_d;
	logic [23:0] base_q, base_d;
	logic pmem_we_q, pmem_we_d;
	logic [23:0] pmem_waddr_q, pmem_waddr_d;
	logic [15:0] pmem_wdata_q, pmem_wdata_d;
	logic nvm_we_q, nvm_we_d;
	logic [9:0] nvm_waddr_q, nvm_waddr_d;
	logic [7:0] nvm_wdata_q, nvm_wdata_d;
	logic erase_q, erase_d;

	// reset pin high holds the shifter cleared, so a new session starts aligned
	assign link_rst_b = i_rst_b & ~i_reset_pin_b;

	smp_link #(.SIGNATURE(SIGNATURE), .CALIBRATION(CALIBRATION)) u_link (
		.i_sck(i_sck),
		.i_rst_b(link_rst_b),
		.i_mosi(i_mosi),
		.o_miso(o_miso),
		.lif(lif)
	);

	smp_sync #(.WIDTH(2)) u_core_sync (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_d({lif.instr_tgl, i_reset_pin_b}),
		.o_q({tgl_s, pin_s})
	);

	// instruction word is stable for 32 serial clocks after its toggle
	assign b1 = lif.instr[31:24];
	assign b2 = lif.instr[23:16];
	assign b3 = lif.instr[15:8];
	assign b4 = lif.instr[7:0];
	assign prog_pin = ~pin_s;
	assign new_instr = tgl_s ^ tgl_prev_q;
	// only enable passes until the port is enabled
	assign accept = new_instr && prog_pin && state_q == smp_pkg::SMP_IDLE &&
		(enabled_q || (b1 == `SMP_OP_AC && b2 == `SMP_EN_B2));
	assign ld_lo = accept && enabled_q && b1 == `SMP_OP_LD_LO;
	assign ld_hi = accept && enabled_q && b1 == `SMP_OP_LD_HI;
	assign ld_nvm = accept && enabled_q && b1 == `SMP_OP_LD_NVM;

	assign lif.busy = state_q != smp_pkg::SMP_IDLE;
	assign lif.lock = lock_q;
	assign lif.fuse_lo = fuse_lo_q;
	assign lif.fuse_hi = fuse_hi_q;
	assign lif.fuse_ext = fuse_ext_q;
	assign lif.ext_addr = ext_q;
	assign lif.pmem_rdata = i_pmem_rdata;
	assign lif.nvm_rdata = i_nvm_rdata;
	assign o_pmem_raddr = lif.pmem_raddr;
	assign o_nvm_raddr = lif.nvm_raddr;

	assign o_miso_oe = prog_pin;
	assign o_prog_mode = enabled_q;
	assign o_cpu_run = pin_s;
	assign o_busy = lif.busy;
	assign o_pmem_we = pmem_we_q;
	assign o_pmem_waddr = pmem_waddr_q;
	assign o_pmem_wdata = pmem_wdata_q;
	assign o_nvm_we = nvm_we_q;
	assign o_nvm_waddr = nvm_waddr_q;
	assign o_nvm_wdata = nvm_wdata_q;
	assign o_chip_erase = erase_q;
	assign o_lock = lock_q;
	assign o_fuse_lo = fuse_lo_q;
	assign o_fuse_hi = fuse_hi_q;
	assign o_fuse_ext = fuse_ext_q;

	// page buffers, no reset since they are plain storage
	always_ff @(posedge i_clock)
	begin
		if (ld_lo)
			pbuf[b3[6:0]][7:0] <= b4;
		if (ld_hi)
			pbuf[b3[6:0]][15:8] <= b4;
		if (ld_nvm)
			nbuf[b3[1:0]] <= b4;
	end

	always_comb
	begin
		state_d = state_q;
		tgt_d = tgt_q;
		enabled_d = enabled_q;
		ext_d = ext_q;
		lock_d = lock_q;
		fuse_lo_d = fuse_lo_q;
		fuse_hi_d = fuse_hi_q;
		fuse_ext_d = fuse_ext_q;
		cnt_d = cnt_q;
		idx_d = idx_q;
		base_d = base_q;
		pmem_we_d = 1'b0;
		pmem_waddr_d = pmem_waddr_q;
		pmem_wdata_d = pmem_wdata_q;
		nvm_we_d = 1'b0;
		nvm_waddr_d = nvm_waddr_q;
		nvm_wdata_d = nvm_wdata_q;
		erase_d = 1'b0;
		if (!prog_pin)
			enabled_d = 1'b0;
		if (accept)
		begin
			unique case (b1)
				`SMP_OP_AC:
				begin
					if (b2 == `SMP_EN_B2)
						enabled_d = 1'b1;
					// erase both arrays, lock bits return to unprogrammed
					else if (b2 == `SMP_ERASE_B2)
					begin
						erase_d = 1'b1;
						lock_d = `SMP_ERASED;
						cnt_d = CW'(ERASE_WAIT_CYC);
						state_d = smp_pkg::SMP_WAIT;
					end
					else if (b2 == `SMP_WR_LOCK_B2 || b2 == `SMP_WR_FUSE_LO_B2 ||
						b2 == `SMP_WR_FUSE_HI_B2 || b2 == `SMP_WR_FUSE_EXT_B2)
					begin
						if (b2 == `SMP_WR_LOCK_B2)
							lock_d = b4;
						if (b2 == `SMP_WR_FUSE_LO_B2)
							fuse_lo_d = b4;
						if (b2 == `SMP_WR_FUSE_HI_B2)
							fuse_hi_d = b4;
						if (b2 == `SMP_WR_FUSE_EXT_B2)
							fuse_ext_d = b4;
						cnt_d = CW'(BYTE_WAIT_CYC);
						state_d = smp_pkg::SMP_WAIT;
					end
				end
				// extended address byte kept until reissued
				`SMP_OP_LD_EXT: ext_d = b3;
				// page base is the word address with the in-page bits dropped
				`SMP_OP_WR_PAGE:
				begin
					base_d = {ext_q, b2, b3[7], 7'h00};
					tgt_d = smp_pkg::SMP_TGT_PMEM;
					idx_d = 7'h00;
					state_d = smp_pkg::SMP_STREAM;
				end
				// single byte, erase and write in one operation
				`SMP_OP_WR_NVM:
				begin
					nvm_we_d = 1'b1;
					nvm_waddr_d = {b2[1:0], b3};
					nvm_wdata_d = b4;
					cnt_d = CW'(BYTE_WAIT_CYC);
					state_d = smp_pkg::SMP_WAIT;
				end
				`SMP_OP_WR_NVM_PG:
				begin
					base_d = {14'h0000, b2[1:0], b3[7:2], 2'h0};
					tgt_d = smp_pkg::SMP_TGT_NVM;
					idx_d = 7'h00;
					state_d = smp_pkg::SMP_STREAM;
				end
				default: ;
			endcase
		end
		unique case (state_q)
			smp_pkg::SMP_IDLE: ;
			smp_pkg::SMP_STREAM:
			begin
				idx_d = idx_q + 7'h01;
				if (tgt_q == smp_pkg::SMP_TGT_PMEM)
				begin
					pmem_we_d = 1'b1;
					pmem_waddr_d = {base_q[23:7], idx_q};
					pmem_wdata_d = pbuf[idx_q];
					if (idx_q == 7'h7F)
					begin
						cnt_d = CW'(PAGE_WAIT_CYC);
						state_d = smp_pkg::SMP_WAIT;
					end
				end
				else
				begin
					// every data byte write erases first
					nvm_we_d = 1'b1;
					nvm_waddr_d = {base_q[9:2], idx_q[1:0]};
					nvm_wdata_d = nbuf[idx_q[1:0]];
					if (idx_q[1:0] == 2'h3)
					begin
						cnt_d = CW'(BYTE_WAIT_CYC);
						state_d = smp_pkg::SMP_WAIT;
					end
				end
			end
			// busy until the self-timed write completes
			smp_pkg::SMP_WAIT:
			begin
				cnt_d = cnt_q - CW'(1);
				if (cnt_q <= CW'(1))
					state_d = smp_pkg::SMP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tgl_prev_q <= 1'b0;
			state_q <= smp_pkg::SMP_IDLE;
			tgt_q <= smp_pkg::SMP_TGT_PMEM;
			enabled_q <= 1'b0;
			ext_q <= 8'h00;
			lock_q <= `SMP_FUSE_RESET;
			fuse_lo_q <= `SMP_FUSE_RESET;
			fuse_hi_q <= `SMP_FUSE_RESET;
			fuse_ext_q <= `SMP_FUSE_RESET;
			cnt_q <= '0;
			idx_q <= 7'h00;
			base_q <= 24'h00_0000;
			pmem_we_q <= 1'b0;
			pmem_waddr_q <= 24'h00_0000;
			pmem_wdata_q <= 16'h0000;
			nvm_we_q <= 1'b0;
			nvm_waddr_q <= 10'h000;
			nvm_wdata_q <= 8'h00;
			erase_q <= 1'b0;
		end
		else
		begin
			tgl_prev_q <= tgl_s;
			state_q <= state_d;
			tgt_q <= tgt_d;
			enabled_q <= enabled_d;
			ext_q <= ext_d;
			lock_q <= lock_d;
			fuse_lo_q <= fuse_lo_d;
			fuse_hi_q <= fuse_hi_d;
			fuse_ext_q <= fuse_ext_d;
			cnt_q <= cnt_d;
			idx_q <= idx_d;
			base_q <= base_d;
			pmem_we_q <= pmem_we_d;
			pmem_waddr_q <= pmem_waddr_d;
			pmem_wdata_q <= pmem_wdata_d;
			nvm_we_q <= nvm_we_d;
			nvm_waddr_q <= nvm_waddr_d;
			nvm_wdata_q <= nvm_wdata_d;
			erase_q <= erase_d;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_erase_req;
		accept && enabled_q && b1 == `SMP_OP_AC && b2 == `SMP_ERASE_B2;
	endsequence
	sequence s_page_req;
		accept && enabled_q && b1 == `SMP_OP_WR_PAGE;
	endsequence
	sequence s_page_stream;
		(o_pmem_we && o_busy) [*8];
	endsequence

	a_locked_out: assert property (new_instr && !enabled_q && b2 != `SMP_EN_B2 |=>
		!o_pmem_we && !o_nvm_we && !o_chip_erase)
		else $error("write started without programming enable");
	a_erase_busy: assert property (s_erase_req |=> o_chip_erase && o_lock == 8'hFF ##1 o_busy [*8])
		else $error("chip erase did not pulse and hold busy");
	a_page_burst: assert property (s_page_req |=> ##1 s_page_stream)
		else $error("page write did not stream words");
	a_page_base: assert property (s_page_req |=> ##1 o_pmem_waddr[6:0] == 7'h00 &&
		o_pmem_waddr[23:7] == {ext_q, $past(b2, 2), $past(b3[7], 2)})
		else $error("page write started away from page base");
	a_ext_hold: assert property ($changed(ext_q) |-> $past(accept && b1 == `SMP_OP_LD_EXT))
		else $error("extended address changed without load");
	a_nvm_byte: assert property (accept && enabled_q && b1 == `SMP_OP_WR_NVM |=>
		o_nvm_we && o_nvm_waddr == {$past(b2[1:0]), $past(b3)} && o_nvm_wdata == $past(b4) ##1 o_busy)
		else $error("data byte write wrong");
	a_fuse_write: assert property (accept && enabled_q && b1 == `SMP_OP_AC && b2 == `SMP_WR_FUSE_HI_B2 |=>
		o_fuse_hi == $past(b4) && o_busy)
		else $error("fuse high write wrong");
	a_leave_mode: assert property (pin_s |=> !o_prog_mode && o_cpu_run)
		else $error("programming mode held after reset release");
	a_busy_refuse: assert property (o_busy && new_instr |=> $stable(ext_q) && !o_chip_erase)
		else $error("instruction taken while busy");
endmodule : smp_port

// ===== hdl/smp_defines.svh
// opcodes, field values and timing constants of the serial programming port
`ifndef SMP_DEFINES_SVH
`define SMP_DEFINES_SVH

`define SMP_OP_AC 8'hAC
`define SMP_EN_B2 8'h53
`define SMP_ERASE_B2 8'h80
`define SMP_WR_LOCK_B2 8'hE0
`define SMP_WR_FUSE_LO_B2 8'hA0
`define SMP_WR_FUSE_HI_B2 8'hA8
`define SMP_WR_FUSE_EXT_B2 8'hA4
`define SMP_OP_POLL 8'hF0
`define SMP_OP_LD_EXT 8'h4D
`define SMP_OP_LD_HI 8'h48
`define SMP_OP_LD_LO 8'h40
`define SMP_OP_LD_NVM 8'hC1
`define SMP_OP_RD_HI 8'h28
`define SMP_OP_RD_LO 8'h20
`define SMP_OP_RD_NVM 8'hA0
`define SMP_OP_RD_LOCK 8'h58
`define SMP_OP_RD_FUSE 8'h50
`define SMP_RD_ALT_B2 8'h08
`define SMP_OP_RD_SIG 8'h30
`define SMP_OP_RD_CAL 8'h38
`define SMP_OP_WR_PAGE 8'h4C
`define SMP_OP_WR_NVM 8'hC0
`define SMP_OP_WR_NVM_PG 8'hC2
`define SMP_ERASED 8'hFF
`define SMP_FUSE_RESET 8'hFF

`define SMP_BIT_ECHO 5'h10
`define SMP_BIT_ADDR 5'h17
`define SMP_BIT_RESP 5'h18
`define SMP_BIT_LAST 5'h1F

`define SMP_CLK_PERIOD_NS 25
`define SMP_PAGE_WAIT_NS 4500000
`define SMP_BYTE_WAIT_NS 3600000
`define SMP_ERASE_WAIT_NS 9000000

`endif

// ===== hdl/smp_pkg.sv
// types shared by the serial programming port modules
package smp_pkg;
	typedef enum logic [2:0] {
		SMP_IDLE = 3'h1,
		SMP_STREAM = 3'h2,
		SMP_WAIT = 3'h4
	} smp_state_t;

	typedef enum logic {
		SMP_TGT_PMEM = 1'h0,
		SMP_TGT_NVM = 1'h1
	} smp_target_t;
endpackage : smp_pkg

// ===== hdl/smp_link_if.sv
// signals between the serial-clock shifter and the core
`timescale 1ns/1ps
interface smp_link_if;
	logic [31:0] instr;
	logic instr_tgl;
	logic busy;
	logic [7:0] lock;
	logic [7:0] fuse_lo;
	logic [7:0] fuse_hi;
	logic [7:0] fuse_ext;
	logic [7:0] ext_addr;
	logic [15:0] pmem_rdata;
	logic [7:0] nvm_rdata;
	logic [23:0] pmem_raddr;
	logic [9:0] nvm_raddr;

	modport link (input busy, lock, fuse_lo, fuse_hi, fuse_ext, ext_addr, pmem_rdata, nvm_rdata,
		output instr, instr_tgl, pmem_raddr, nvm_raddr);
	modport core (output busy, lock, fuse_lo, fuse_hi, fuse_ext, ext_addr, pmem_rdata, nvm_rdata,
		input instr, instr_tgl, pmem_raddr, nvm_raddr);
endinterface : smp_link_if

// ===== hdl/smp_sync.sv
// two-flop synchroniser for level signals
`timescale 1ns/1ps
module smp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("smp_sync width must be at least one");
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_q <= '0;
			o_q <= '0;
		end
		else
		begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule : smp_sync

// ===== hdl/smp_link.sv
// serial-clock domain: instruction shifter and output byte
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_link #(
	parameter logic [23:0] SIGNATURE = 24'h5A_A5C3,
	parameter logic [7:0] CALIBRATION = 8'h80
) (
	input wire logic i_sck,
	input wire logic i_rst_b,
	input wire logic i_mosi,
	output logic o_miso,
	smp_link_if.link lif
);
	logic [4:0] cnt_q, cnt_d;
	logic [31:0] sh_q, sh_d;
	logic [31:0] instr_q, instr_d;
	logic tgl_q, tgl_d;
	logic [7:0] out_q, out_d;
	logic [7:0] resp;
	logic busy_s;
	logic [7:0] b1, b2, b3;
	logic [15:0] radr_q, radr_d;

	// busy changes rarely; a stale sample only delays the poll by one instruction
	smp_sync #(.WIDTH(1)) u_busy_sync (
		.i_clock(i_sck),
		.i_rst_b(i_rst_b),
		.i_d(lif.busy),
		.o_q(busy_s)
	);

	assign b1 = sh_q[23:16];
	assign b2 = sh_q[15:8];
	assign b3 = sh_q[7:0];
	assign lif.instr = instr_q;
	assign lif.instr_tgl = tgl_q;
	// read address captured on the third byte's last edge; the shifter moves on during byte four
	assign lif.pmem_raddr = {lif.ext_addr, radr_q};
	assign lif.nvm_raddr = radr_q[9:0];
	assign o_miso = out_q[7];

	// capture on rising edge, four bytes MSB first
	always_comb
	begin
		sh_d = {sh_q[30:0], i_mosi};
		cnt_d = cnt_q + 5'h1;
		instr_d = instr_q;
		tgl_d = tgl_q;
		radr_d = radr_q;
		if (cnt_q == `SMP_BIT_ADDR)
			radr_d = sh_d[15:0];
		if (cnt_q == `SMP_BIT_LAST)
		begin
			instr_d = sh_d;
			tgl_d = ~tgl_q;
		end
	end

	always_ff @(posedge i_sck or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q <= '0;
			sh_q <= '0;
			instr_q <= '0;
			tgl_q <= 1'b0;
			radr_q <= 16'h0000;
		end
		else
		begin
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			instr_q <= instr_d;
			tgl_q <= tgl_d;
			radr_q <= radr_d;
		end
	end

	always_comb
	begin
		resp = 8'h00;
		unique case (b1)
			`SMP_OP_POLL: resp = {7'h00, busy_s};
			`SMP_OP_RD_HI: resp = lif.pmem_rdata[15:8];
			`SMP_OP_RD_LO: resp = lif.pmem_rdata[7:0];
			`SMP_OP_RD_NVM: resp = lif.nvm_rdata;
			`SMP_OP_RD_LOCK: resp = (b2 == `SMP_RD_ALT_B2) ? lif.fuse_hi : lif.lock;
			`SMP_OP_RD_FUSE: resp = (b2 == `SMP_RD_ALT_B2) ? lif.fuse_ext : lif.fuse_lo;
			`SMP_OP_RD_SIG: resp = (b3[1:0] == 2'h3) ? 8'h00 : SIGNATURE[8*b3[1:0] +: 8];
			`SMP_OP_RD_CAL: resp = CALIBRATION;
			default: resp = 8'h00;
		endcase
	end

	// output shifts on falling edge; echo second byte during third
	always_comb
	begin
		if (cnt_q == `SMP_BIT_ECHO)
			out_d = b3;
		else if (cnt_q == `SMP_BIT_RESP)
			out_d = resp;
		else
			out_d = {out_q[6:0], 1'b0};
	end

	always_ff @(negedge i_sck or negedge i_rst_b)
	begin
		if (!i_rst_b)
			out_q <= '0;
		else
			out_q <= out_d;
	end
endmodule : smp_link

// ===== test/smp_prog_model.sv
// programmer model: drives the serial link and the device reset pin
`timescale 1ns/1ps
module smp_prog_model #(
	parameter int SETTLE_NS = 2000
) (
	output logic o_sck,
	output logic o_mosi,
	output logic o_pin_b,
	input wire logic i_miso
);
	initial
	begin
		o_sck = 1'b0;
		o_mosi = 1'b0;
		o_pin_b = 1'b0;
	end

	task automatic settle();
		#(SETTLE_NS);
	endtask : settle

	task automatic pin(input logic v);
		o_pin_b = v;
		#100;
	endtask : pin

	task automatic xfer(input logic [31:0] w, output logic [31:0] r);
		for (int i = 31; i >= 0; i--)
		begin
			o_mosi = w[i];
			#24 o_sck = 1'b1;
			r[i] = i_miso;
			#24 o_sck = 1'b0;
		end
		// no pull on the line, so show the inverse once released
		o_mosi = ~o_mosi;
		// clock stands still while the core takes the word
		#200;
	endtask : xfer
endmodule : smp_prog_model

// ===== test/test_serial_memory_programming_port.sv
// self-checking bench of the serial programming port
`timescale 1ns/1ps
module test_serial_memory_programming_port;
	localparam logic [23:0] SIG = 24'h12_3456;
	localparam logic [7:0] CAL = 8'h9C;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic sck, mosi, pin_b, miso, miso_oe, prog_mode, cpu_run, busy, pm_we, nv_we, ce;
	logic [23:0] pm_ra, pm_wa, pg_base;
	logic [15:0] pm_rd, pm_wd;
	logic [9:0] nv_ra, nv_wa, lst_wa;
	logic [7:0] nv_rd, nv_wd, lst_wd, lock, f_lo, f_hi, f_ext;
	int n_errors = 0;
	int cmp_count = 0;
	int n_pwe = 0;
	int n_nwe = 0;
	int n_ce = 0;

	// arrays outside the block: read data derived from the address
	assign pm_rd = pm_ra[15:0] ^ 16'hC3_5A;
	assign nv_rd = nv_ra[7:0] ^ 8'h5A;

	always #12.5 i_clock = ~i_clock;

	smp_prog_model smp_prog_model_inst (.o_sck(sck), .o_mosi(mosi), .o_pin_b(pin_b), .i_miso(miso));

	smp_port #(
		.PAGE_WAIT_CYC(20),
		.BYTE_WAIT_CYC(16),
		.ERASE_WAIT_CYC(30),
		.SIGNATURE(SIG),
		.CALIBRATION(CAL)
	) smp_port_inst (
		.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reset_pin_b(pin_b), .i_sck(sck), .i_mosi(mosi),
		.o_miso(miso), .o_miso_oe(miso_oe), .o_prog_mode(prog_mode), .o_cpu_run(cpu_run), .o_busy(busy),
		.o_pmem_raddr(pm_ra), .i_pmem_rdata(pm_rd), .o_nvm_raddr(nv_ra), .i_nvm_rdata(nv_rd),
		.o_pmem_we(pm_we), .o_pmem_waddr(pm_wa), .o_pmem_wdata(pm_wd), .o_nvm_we(nv_we),
		.o_nvm_waddr(nv_wa), .o_nvm_wdata(nv_wd), .o_chip_erase(ce), .o_lock(lock),
		.o_fuse_lo(f_lo), .o_fuse_hi(f_hi), .o_fuse_ext(f_ext)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	always @(posedge i_clock)
	begin
		if (pm_we === 1'b1)
		begin
			chk(pm_wa, pg_base + 24'(n_pwe));
			chk(pm_wd, {8'(n_pwe) ^ 8'hFF, 8'(n_pwe)});
			n_pwe++;
		end
		if (nv_we === 1'b1)
		begin
			lst_wa <= nv_wa;
			lst_wd <= nv_wd;
			n_nwe++;
		end
		if (ce === 1'b1)
			n_ce++;
	end

	// polling keeps the next instruction off a write in progress
	task automatic wr(input logic [31:0] w, output logic b0);
		logic [31:0] r;
		int k;
		smp_prog_model_inst.xfer(w, r);
		smp_prog_model_inst.xfer(32'hF000_0000, r);
		b0 = r[0];
		k = 0;
		while (r[0] !== 1'b0 && k < 40)
		begin
			smp_prog_model_inst.xfer(32'hF000_0000, r);
			k++;
		end
		chk(r[0], 1'b0);
		chk(busy, 1'b0);
	endtask : wr

	task automatic t_refuse();
		logic [31:0] r;
		smp_prog_model_inst.xfer(32'hAC80_0000, r);
		chk(r[15:8], 8'h80);
		chk(n_ce, 0);
		chk(prog_mode, 1'b0);
	endtask : t_refuse

	task automatic t_enable();
		logic [31:0] r;
		smp_prog_model_inst.xfer(32'hAC53_0000, r);
		chk(r[15:8], 8'h53);
		chk({prog_mode, cpu_run, miso_oe}, 3'b101);
	endtask : t_enable

	task automatic t_fuse();
		logic [7:0] wc[4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
		logic [15:0] rc[4] = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
		logic [7:0] v[4] = '{8'hF3, 8'h62, 8'hD9, 8'hFD};
		logic [31:0] r;
		logic b;
		for (int i = 0; i < 4; i++)
		begin
			wr({8'hAC, wc[i], 8'h00, v[i]}, b);
			smp_prog_model_inst.xfer({rc[i], 16'h0000}, r);
			chk(r[7:0], v[i]);
		end
		chk({lock, f_lo, f_hi, f_ext}, {v[0], v[1], v[2], v[3]});
	endtask : t_fuse

	task automatic t_page();
		logic [31:0] r;
		logic b;
		wr(32'h4D00_0100, b);
		for (int i = 0; i < 128; i++)
		begin
			smp_prog_model_inst.xfer({8'h40, 8'h00, 8'(i), 8'(i)}, r);
			smp_prog_model_inst.xfer({8'h48, 8'h00, 8'(i), 8'(i) ^ 8'hFF}, r);
		end
		pg_base = 24'h01_1280;
		n_pwe = 0;
		wr(32'h4C12_8500, b);
		chk(b, 1'b1);
		chk(n_pwe, 128);
	endtask : t_page

	task automatic t_read();
		logic [31:0] r;
		smp_prog_model_inst.xfer(32'h2812_3400, r);
		chk(pm_ra, 24'h01_1234);
		chk(r[7:0], 8'h12 ^ 8'hC3);
		smp_prog_model_inst.xfer(32'h2012_3400, r);
		chk(r[7:0], 8'h34 ^ 8'h5A);
		smp_prog_model_inst.xfer(32'hA002_3500, r);
		chk(nv_ra, 10'h235);
		chk(r[7:0], 8'h35 ^ 8'h5A);
		for (int i = 0; i < 3; i++)
		begin
			smp_prog_model_inst.xfer({8'h30, 8'h00, 8'(i), 8'h00}, r);
			chk(r[7:0], SIG[8*i +: 8]);
		end
		smp_prog_model_inst.xfer(32'h3800_0000, r);
		chk(r[7:0], CAL);
	endtask : t_read

	task automatic t_nvm();
		logic [31:0] r;
		logic b;
		n_nwe = 0;
		wr(32'hC003_FFAB, b);
		chk({n_nwe[3:0], lst_wa, lst_wd}, {4'h1, 10'h3FF, 8'hAB});
		for (int i = 0; i < 4; i++)
			smp_prog_model_inst.xfer({8'hC1, 8'h00, 8'(i), 8'h10 + 8'(i)}, r);
		wr(32'hC201_4400, b);
		chk({n_nwe[3:0], lst_wa, lst_wd}, {4'h5, 10'h147, 8'h13});
	endtask : t_nvm

	task automatic t_erase();
		logic b;
		wr(32'hAC80_0000, b);
		chk(n_ce, 1);
		chk(lock, 8'hFF);
	endtask : t_erase

	task automatic t_exit();
		smp_prog_model_inst.pin(1'b1);
		repeat (4) @(posedge i_clock);
		chk({prog_mode, cpu_run, miso_oe}, 3'b010);
	endtask : t_exit

	task automatic test_done();
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (16) @(posedge i_clock);
		#2 i_rst_b = 1'b1;
		smp_prog_model_inst.settle();
		t_refuse();
		t_enable();
		t_fuse();
		t_page();
		t_read();
		t_nvm();
		t_erase();
		t_exit();
		test_done();
	end

	// about 290 frames of under 2 us each fit well inside this span
	initial
	begin
		#2_000_000;
		n_errors++;
		test_done();
	end
endmodule : test_serial_memory_programming_port
